// >>> rtl/tmr_pkg.sv
/*
 * Constants, codes and the state record of the 8-bit timer/counter block.
 * Assumes an APB slave with 32-bit data; register indices are word numbers.
 */
package tmr_pkg;
    // Bus address width, enough for index 0xff at four bytes per word
    localparam int unsigned ADDR_W = 12;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CTL_A = 8'h24;
    localparam logic [7:0] IDX_CTL_B = 8'h25;
    localparam logic [7:0] IDX_COUNT = 8'h26;
    localparam logic [7:0] IDX_CMP_A = 8'h27;
    localparam logic [7:0] IDX_CMP_B = 8'h28;
    localparam logic [7:0] IDX_MASK = 8'h2e;
    localparam logic [7:0] IDX_FLAGS = 8'h15;

    // Field positions
    localparam int unsigned FORCE_A_BIT = 7;
    localparam int unsigned FORCE_B_BIT = 6;
    localparam int unsigned WM_MSB_BIT = 3;
    localparam int unsigned OVF_BIT = 0;
    localparam int unsigned MATCH_A_BIT = 1;
    localparam int unsigned MATCH_B_BIT = 2;

    // Writable bits; the rest read as zero
    localparam logic [7:0] CTL_A_WMASK = 8'hf3;
    localparam logic [7:0] CTL_B_WMASK = 8'h0f;
    localparam logic [2:0] IRQ_WMASK = 3'h7;

    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_IRQ = 3'h0;

    // Counter limits
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;

    // Prescaler width and tap widths for /8, /64, /256, /1024
    localparam int unsigned PRE_W = 10;
    localparam int unsigned TAP8_W = 3;
    localparam int unsigned TAP64_W = 6;
    localparam int unsigned TAP256_W = 8;
    localparam int unsigned TAP1024_W = 10;

    typedef enum logic [2:0] {
        CS_STOP = 3'b000,
        CS_DIV1 = 3'b001,
        CS_DIV8 = 3'b010,
        CS_DIV64 = 3'b011,
        CS_DIV256 = 3'b100,
        CS_DIV1024 = 3'b101,
        CS_EXT_FALL = 3'b110,
        CS_EXT_RISE = 3'b111
    } tmr_cs_t;

    // Output actions of a compare channel
    localparam logic [1:0] ACT_NONE = 2'b00;
    localparam logic [1:0] ACT_TOGGLE = 2'b01;
    localparam logic [1:0] ACT_CLEAR = 2'b10;
    localparam logic [1:0] ACT_SET = 2'b11;

    typedef struct packed {
        logic [7:0] ctl_a;
        logic [7:0] ctl_b;
        logic [7:0] cnt;
        logic [1:0][7:0] ocr;
        logic [2:0] mask;
        logic [2:0] flags;
        logic [PRE_W-1:0] presc;
        logic [2:0] sync;
        logic dir;
        logic block;
        logic [1:0] wave;
        logic [1:0] wave_en;
        logic irq;
        logic pready;
        logic pslverr;
        logic [7:0] prdata;
    } tmr_state_t;
endpackage : tmr_pkg

// >>> rtl/tmr_timer8.sv
/*
 * 8-bit timer/counter with two compare channels, registers over APB.
 * Assumes one clock mclk_i, asynchronous active-low reset, and a CPU that
 * signals interrupt vector entry on vec_ack_i and its global enable on gie_i.
 */
// The APB slave port was chosen for this implementation.
// How it works
// - Force strobes act only in non-PWM wave modes; ignored in PWM modes.
// - A force strobe applies an immediate match to that channel's output action.
// - A force strobe sets no flag and never clears the counter.
// - Force bits always read back as zero.
// - Control B bit 3 is the wave mode top bit, joined to the two low bits.
// - Source select: 0 stop, 1 undivided, 2..5 prescaler taps 8/64/256/1024.
// - Source codes 6 and 7 count falling or rising edges of the count pin.
// - The count pin is sampled regardless of its direction setting.
// - The count register reads and writes the 8-bit counter directly.
// - Writing the count register blocks matches on the next timer tick.
// - Both compare registers are compared always; matches flag and shape outputs.
// - Mask bits 2,1,0 enable match B, match A, overflow; global bit also needed.
// - Match A and B set flag bits 1 and 2.
// - Flags clear on vector entry or on a written one.
// - Overflow flag bit 0 sets at a point chosen by the wave mode.
// - Three wave mode bits pick count sequence, top source and waveform type.
// - Non-PWM actions 01/10/11 toggle, clear, set; 00 leaves the pin to the port.
`timescale 1ns/1ps
module tmr_timer8 (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [tmr_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic ext_count_pin_i,
    input wire logic gie_i,
    input wire logic [2:0] vec_ack_i,
    output logic wave_out_a_o,
    output logic wave_out_b_o,
    output logic wave_en_a_o,
    output logic wave_en_b_o,
    output logic irq_o
);
    import tmr_pkg::*;

    tmr_state_t s_q;
    tmr_state_t s_d;
    logic acc_w;
    logic aligned_w;
    logic mapped_w;
    logic wr_w;
    logic cnt_wr_w;
    logic ctlb_wr_w;
    logic tick_w;
    logic ext_rise_w;
    logic ext_fall_w;
    logic pwm_w;
    logic [7:0] idx_w;
    logic [7:0] rd_w;
    logic [7:0] top_w;
    logic [2:0] wm_w;
    logic [1:0] match_w;
    logic [1:0] force_w;

    // Bus decode; a write commits at the edge where pready is seen high
    assign acc_w = psel_i && penable_i;
    assign idx_w = paddr_i[9:2];
    // Upper address bits must be zero too, else registers would alias
    assign aligned_w = (paddr_i[1:0] == 2'b00) && (paddr_i[ADDR_W-1:10] == '0);
    assign mapped_w = aligned_w && (idx_w == IDX_CTL_A || idx_w == IDX_CTL_B ||
        idx_w == IDX_COUNT || idx_w == IDX_CMP_A || idx_w == IDX_CMP_B ||
        idx_w == IDX_MASK || idx_w == IDX_FLAGS);
    assign wr_w = acc_w && pwrite_i && s_q.pready && aligned_w;
    assign cnt_wr_w = wr_w && (idx_w == IDX_COUNT);
    assign ctlb_wr_w = wr_w && (idx_w == IDX_CTL_B);

    // Mode decode: odd modes are the PWM ones
    assign wm_w = {s_q.ctl_b[WM_MSB_BIT], s_q.ctl_a[1:0]};
    assign pwm_w = wm_w[0];
    assign top_w = wm_w[2] ? s_q.ocr[0] : CNT_MAX;

    // Edges seen only after the second stage; stage one feeds nothing else
    assign ext_rise_w = s_q.sync[1] && !s_q.sync[2];
    assign ext_fall_w = !s_q.sync[1] && s_q.sync[2];

    // Force only outside PWM modes, and never stored
    assign force_w = (ctlb_wr_w && !pwm_w) ?
        {pwdata_i[FORCE_B_BIT], pwdata_i[FORCE_A_BIT]} : 2'b00;

    // Timer tick from the selected source
    always_comb begin
        case (tmr_cs_t'(s_q.ctl_b[2:0]))
            CS_STOP: tick_w = 1'b0;
            CS_DIV1: tick_w = 1'b1;
            CS_DIV8: tick_w = &s_q.presc[TAP8_W-1:0];
            CS_DIV64: tick_w = &s_q.presc[TAP64_W-1:0];
            CS_DIV256: tick_w = &s_q.presc[TAP256_W-1:0];
            CS_DIV1024: tick_w = &s_q.presc[TAP1024_W-1:0];
            CS_EXT_FALL: tick_w = ext_fall_w;
            CS_EXT_RISE: tick_w = ext_rise_w;
            default: tick_w = 1'b0;
        endcase
    end

    // Matches need a tick; a pending count write blocks them
    assign match_w[0] = tick_w && !cnt_wr_w && !s_q.block &&
        (s_q.cnt == s_q.ocr[0]);
    assign match_w[1] = tick_w && !cnt_wr_w && !s_q.block &&
        (s_q.cnt == s_q.ocr[1]);

    // Read mux; reserved and strobe bits come back as zero
    always_comb begin
        case (idx_w)
            IDX_CTL_A: rd_w = s_q.ctl_a & CTL_A_WMASK;
            IDX_CTL_B: rd_w = s_q.ctl_b & CTL_B_WMASK;
            IDX_COUNT: rd_w = s_q.cnt;
            IDX_CMP_A: rd_w = s_q.ocr[0];
            IDX_CMP_B: rd_w = s_q.ocr[1];
            IDX_MASK: rd_w = {5'h00, s_q.mask};
            IDX_FLAGS: rd_w = {5'h00, s_q.flags};
            default: rd_w = RST_BYTE;
        endcase
    end

    // Next state of the whole block
    always_comb begin
        logic ovf;
        logic bottom;
        logic [1:0] act;
        logic [2:0] fset;
        logic [2:0] fclr;
        ovf = 1'b0;
        bottom = 1'b0;
        act = ACT_NONE;
        fset = 3'h0;
        fclr = 3'h0;
        s_d = s_q;
        s_d.presc = s_q.presc + 1'b1;
        s_d.sync = {s_q.sync[1:0], ext_count_pin_i};

        // One wait state: data captured in the first access cycle
        s_d.pready = acc_w && !s_q.pready;
        s_d.pslverr = acc_w && !s_q.pready && !mapped_w;
        if (acc_w && !s_q.pready) begin
            s_d.prdata = mapped_w ? rd_w : RST_BYTE;
        end

        // Block lasts until the next timer tick
        if (tick_w) begin
            s_d.block = 1'b0;
        end

        // Counting sequence per wave mode
        if (tick_w) begin
            if (pwm_w && !wm_w[1]) begin
                // Dual slope: turn at top, overflow at bottom
                if (s_q.dir) begin
                    if (s_q.cnt == top_w) begin
                        s_d.dir = 1'b0;
                        s_d.cnt = s_q.cnt - 1'b1;
                    end else begin
                        s_d.cnt = s_q.cnt + 1'b1;
                    end
                end else if (s_q.cnt == CNT_BOTTOM) begin
                    s_d.dir = 1'b1;
                    s_d.cnt = s_q.cnt + 1'b1;
                    ovf = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end else begin
                // Single slope: wrap at top (fast PWM) or compare A (CTC)
                s_d.dir = 1'b1;
                if ((wm_w == 3'b010 && s_q.cnt == s_q.ocr[0]) ||
                        (pwm_w && s_q.cnt == top_w) || s_q.cnt == CNT_MAX) begin
                    s_d.cnt = CNT_BOTTOM;
                    bottom = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
                ovf = (wm_w == 3'b111) ? (s_q.cnt == top_w) : (s_q.cnt == CNT_MAX);
            end
        end

        // Output actions per channel
        for (int i = 0; i < 2; i++) begin
            act = (i == 0) ? s_q.ctl_a[7:6] : s_q.ctl_a[5:4];
            if (!pwm_w) begin
                // Force behaves as a match here but touches no flag
                if (match_w[i] || force_w[i]) begin
                    case (act)
                        ACT_TOGGLE: s_d.wave[i] = !s_q.wave[i];
                        ACT_CLEAR: s_d.wave[i] = 1'b0;
                        ACT_SET: s_d.wave[i] = 1'b1;
                        default: s_d.wave[i] = s_q.wave[i];
                    endcase
                end
            end else if (match_w[i]) begin
                // PWM: phase correct flips sense on the down slope
                case (act)
                    ACT_CLEAR: s_d.wave[i] = wm_w[1] ? 1'b0 : !s_q.dir;
                    ACT_SET: s_d.wave[i] = wm_w[1] ? 1'b1 : s_q.dir;
                    ACT_TOGGLE: s_d.wave[i] = (i == 0 && wm_w[2]) ? !s_q.wave[i] : s_q.wave[i];
                    default: s_d.wave[i] = s_q.wave[i];
                endcase
            end else if (bottom && wm_w[1]) begin
                if (act == ACT_CLEAR) begin
                    s_d.wave[i] = 1'b1;
                end else if (act == ACT_SET) begin
                    s_d.wave[i] = 1'b0;
                end
            end
        end

        // Register writes; a count write beats the tick in the same cycle
        if (wr_w) begin
            case (idx_w)
                IDX_CTL_A: s_d.ctl_a = pwdata_i[7:0] & CTL_A_WMASK;
                IDX_CTL_B: s_d.ctl_b = pwdata_i[7:0] & CTL_B_WMASK;
                IDX_COUNT: begin
                    s_d.cnt = pwdata_i[7:0];
                    s_d.block = 1'b1;
                end
                IDX_CMP_A: s_d.ocr[0] = pwdata_i[7:0];
                IDX_CMP_B: s_d.ocr[1] = pwdata_i[7:0];
                IDX_MASK: s_d.mask = pwdata_i[2:0] & IRQ_WMASK;
                IDX_FLAGS: fclr = pwdata_i[2:0] & IRQ_WMASK;
                default: s_d.mask = s_q.mask;
            endcase
        end

        // Flags: hardware set wins over any clear in the same cycle
        fset[OVF_BIT] = ovf;
        fset[MATCH_A_BIT] = match_w[0];
        fset[MATCH_B_BIT] = match_w[1];
        fclr = fclr | vec_ack_i;
        s_d.flags = (s_q.flags & ~fclr) | fset;

        // Interrupt follows the flags of the same edge
        s_d.irq = gie_i && |(s_d.flags & s_d.mask);
        s_d.wave_en = {s_d.ctl_a[5:4] != ACT_NONE, s_d.ctl_a[7:6] != ACT_NONE};
    end

    // Single state register
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Every output straight from the state register
    assign prdata_o = {24'h000000, s_q.prdata};
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign wave_out_a_o = s_q.wave[0];
    assign wave_out_b_o = s_q.wave[1];
    assign wave_en_a_o = s_q.wave_en[0];
    assign wave_en_b_o = s_q.wave_en[1];
    assign irq_o = s_q.irq;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    // Force in PWM mode must leave the outputs alone when no match occurs
    property p_force_pwm;
        (ctlb_wr_w && pwm_w && match_w == 2'b00 && tick_w == 1'b0) |=> $stable(s_q.wave);
    endproperty
    a_force_pwm: assert property (p_force_pwm) else $error("force acted in PWM mode");

    // Force with an action of set drives the output high next cycle
    property p_force_set;
        (force_w[0] && s_q.ctl_a[7:6] == ACT_SET) |=> s_q.wave[0];
    endproperty
    a_force_set: assert property (p_force_set) else $error("force did not set output");

    // Force without a real match never raises a match flag
    property p_force_noflag;
        (force_w[0] && !match_w[0] && !s_q.flags[MATCH_A_BIT]) |=> !s_q.flags[MATCH_A_BIT];
    endproperty
    a_force_noflag: assert property (p_force_noflag) else $error("force set a flag");

    // Control B reads never show the strobe bits
    property p_strobe_zero;
        (pready_o && !pslverr_o) |-> prdata_o[7:4] == 4'h0 || $past(idx_w) != IDX_CTL_B;
    endproperty
    a_strobe_zero: assert property (p_strobe_zero) else $error("strobe bits read as one");

    // A count write lands and sets the block for the tick that follows
    property p_cnt_write;
        cnt_wr_w |=> (s_q.cnt == $past(pwdata_i[7:0])) && s_q.block;
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("count write lost");

    // The tick right after a count write raises no match flag
    property p_block;
        (s_q.block && tick_w && !s_q.flags[MATCH_A_BIT]) |=> !s_q.flags[MATCH_A_BIT];
    endproperty
    a_block: assert property (p_block) else $error("match during block");

    // Stopped source leaves the counter still
    property p_stop;
        (s_q.ctl_b[2:0] == CS_STOP && !cnt_wr_w) |=> $stable(s_q.cnt);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");

    // Rising-edge source counts only on a synchronised rising edge
    property p_ext_rise;
        (s_q.ctl_b[2:0] == CS_EXT_RISE && !ext_rise_w && !cnt_wr_w) |=> $stable(s_q.cnt);
    endproperty
    a_ext_rise: assert property (p_ext_rise) else $error("count without pin edge");

    // A real match sets its flag and, if enabled, raises the interrupt
    property p_match_flag;
        (match_w[1] && s_q.mask[MATCH_B_BIT] && gie_i) |=> s_q.flags[MATCH_B_BIT] && irq_o;
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("match B not flagged");

    // Vector entry clears a flag unless a new event arrives
    property p_vec_clear;
        (vec_ack_i[OVF_BIT] && !tick_w) |=> !s_q.flags[OVF_BIT];
    endproperty
    a_vec_clear: assert property (p_vec_clear) else $error("vector did not clear flag");

    // A written one clears the flag when no new match arrives
    property p_w1c;
        (wr_w && idx_w == IDX_FLAGS && pwdata_i[MATCH_A_BIT] && !match_w[0]) |=> !s_q.flags[MATCH_A_BIT];
    endproperty
    a_w1c: assert property (p_w1c) else $error("written one did not clear flag");

    // Falling-edge source counts only on a synchronised falling edge
    property p_ext_fall;
        (s_q.ctl_b[2:0] == CS_EXT_FALL && !ext_fall_w && !cnt_wr_w) |=> $stable(s_q.cnt);
    endproperty
    a_ext_fall: assert property (p_ext_fall) else $error("count without falling edge");

    // A pin rise reaches the edge detector after two synchroniser stages
    property p_sync_delay;
        $rose(ext_count_pin_i) |-> ##2 ext_rise_w;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("pin edge not seen");

    // Divide-by-8 source holds the count between prescaler taps
    property p_div8;
        (s_q.ctl_b[2:0] == CS_DIV8 && !(&s_q.presc[TAP8_W-1:0]) && !cnt_wr_w)
            |=> $stable(s_q.cnt);
    endproperty
    a_div8: assert property (p_div8) else $error("count moved between taps");

    // Clear-on-compare: a match with compare A sends the count to bottom
    property p_ctc_wrap;
        (wm_w == 3'b010 && tick_w && s_q.cnt == s_q.ocr[0] && !cnt_wr_w)
            |=> s_q.cnt == CNT_BOTTOM;
    endproperty
    a_ctc_wrap: assert property (p_ctc_wrap) else $error("no wrap at compare A");

    // Normal mode flags overflow on the tick at the maximum count
    property p_ovf_normal;
        (wm_w == 3'b000 && tick_w && s_q.cnt == CNT_MAX) |=> s_q.flags[OVF_BIT];
    endproperty
    a_ovf_normal: assert property (p_ovf_normal) else $error("overflow not flagged");

    // Without the global enable the line drops at the next edge
    property p_gie_off;
        !gie_i |=> !irq_o;
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("interrupt without global enable");

    // With every enable cleared the line stays low
    property p_mask_off;
        (s_q.mask == 3'h0) |-> !irq_o;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("interrupt while masked");
endmodule : tmr_timer8

// >>> dv/tb_top.sv
/*
 * Self-checking bench for the 8-bit timer/counter: registers over APB, force
 * strobes, compare and overflow flags, interrupt line, external count pin.
 * Assumes tmr_pkg is compiled first; assertions live in the design files.
 */
`timescale 1ns/1ps
module tb_top;
    import tmr_pkg::*;
    logic mclk_i, nrst_i, psel_i, penable_i, pwrite_i, ext_count_pin_i, gie_i;
    logic [ADDR_W-1:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic [2:0] vec_ack_i;
    logic pready_o, pslverr_o, wave_out_a_o, wave_out_b_o, wave_en_a_o, wave_en_b_o, irq_o;
    int failures, n_checks;
    logic [31:0] rd_q;
    logic err_q;

    tmr_timer8 dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_count_pin_i(ext_count_pin_i),
        .gie_i(gie_i), .vec_ack_i(vec_ack_i), .wave_out_a_o(wave_out_a_o),
        .wave_out_b_o(wave_out_b_o), .wave_en_a_o(wave_en_a_o), .wave_en_b_o(wave_en_b_o),
        .irq_o(irq_o));

    // Free-running 125 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    // One APB transfer; waits for pready with a bound, never a fixed latency
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int i;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= {2'b00, idx, 2'b00};
        pwdata_i <= {24'h000000, d};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk_i);
            if (pready_o === 1'b1) break;
        end
        if (i == 20) begin
            failures++;
            results();
        end
        rd_q = prdata_o;
        err_q = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd_q, {24'h000000, exp});
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : idle

    // Reset values, plus an unmapped index that must be refused
    task automatic t_reset();
        rd(IDX_CTL_B, RST_BYTE);
        rd(IDX_COUNT, RST_BYTE);
        rd(IDX_CMP_A, RST_BYTE);
        rd(IDX_CMP_B, RST_BYTE);
        rd(IDX_MASK, RST_BYTE);
        rd(IDX_FLAGS, RST_BYTE);
        apb(1'b0, 8'h00, 8'h00);
        check({31'h0, err_q}, 32'h1);
        check(rd_q, 32'h0);
        $display("test reset done");
    endtask : t_reset

    // Force strobes act in CTC mode and keep the count, ignored in PWM, set no flag
    task automatic t_force();
        wr(IDX_CTL_A, 8'h72);
        wr(IDX_COUNT, 8'h05);
        wr(IDX_CTL_B, 8'hc0);
        idle(3);
        check({30'h0, wave_out_a_o, wave_out_b_o}, 32'h3);
        check({30'h0, wave_en_a_o, wave_en_b_o}, 32'h3);
        wr(IDX_CTL_B, 8'hc0);
        idle(3);
        check({30'h0, wave_out_a_o, wave_out_b_o}, 32'h1);
        rd(IDX_CTL_B, 8'h00);
        rd(IDX_FLAGS, 8'h00);
        rd(IDX_COUNT, 8'h05);
        wr(IDX_CTL_A, 8'h73);
        wr(IDX_CTL_B, 8'hc0);
        idle(3);
        check({30'h0, wave_out_a_o, wave_out_b_o}, 32'h1);
        wr(IDX_CTL_A, 8'h00);
        idle(2);
        check({30'h0, wave_en_a_o, wave_en_b_o}, 32'h0);
        wr(IDX_CTL_B, 8'h08);
        rd(IDX_CTL_B, 8'h08);
        wr(IDX_CTL_B, 8'h00);
        $display("test force done");
    endtask : t_force

    // Compare matches, mask and global enable, both ways of clearing
    task automatic t_match();
        wr(IDX_CMP_A, 8'h08);
        wr(IDX_CMP_B, 8'h0c);
        wr(IDX_COUNT, 8'h00);
        wr(IDX_MASK, 8'h06);
        gie_i <= 1'b1;
        wr(IDX_CTL_B, {5'h00, CS_DIV1});
        idle(40);
        wr(IDX_CTL_B, {5'h00, CS_STOP});
        rd(IDX_FLAGS, 8'h06);
        idle(1);
        check({31'h0, irq_o}, 32'h1);
        gie_i <= 1'b0;
        idle(2);
        check({31'h0, irq_o}, 32'h0);
        gie_i <= 1'b1;
        wr(IDX_MASK, 8'h00);
        rd(IDX_MASK, 8'h00);
        idle(1);
        check({31'h0, irq_o}, 32'h0);
        wr(IDX_FLAGS, 8'h02);
        rd(IDX_FLAGS, 8'h04);
        @(posedge mclk_i);
        vec_ack_i <= 3'h4;
        @(posedge mclk_i);
        vec_ack_i <= 3'h0;
        rd(IDX_FLAGS, 8'h00);
        $display("test match done");
    endtask : t_match

    // Overflow through the divide-by-8 tap, cleared by vector entry
    task automatic t_overflow();
        int i;
        wr(IDX_COUNT, 8'hf8);
        wr(IDX_MASK, 8'h01);
        wr(IDX_CTL_B, {5'h00, CS_DIV8});
        idle(8 * 4);
        rd(IDX_FLAGS, 8'h00);
        for (i = 0; i < 40; i++) begin
            apb(1'b0, IDX_FLAGS, 8'h00);
            if (rd_q[OVF_BIT] === 1'b1) break;
        end
        check({31'h0, rd_q[OVF_BIT]}, 32'h1);
        check({31'h0, irq_o}, 32'h1);
        wr(IDX_CTL_B, {5'h00, CS_STOP});
        @(posedge mclk_i);
        vec_ack_i <= 3'h1;
        @(posedge mclk_i);
        vec_ack_i <= 3'h0;
        rd(IDX_FLAGS, 8'h00);
        $display("test overflow done");
    endtask : t_overflow

    // Count pin edges, rising then falling; slow enough for the synchroniser
    task automatic t_extpin();
        wr(IDX_COUNT, 8'h00);
        wr(IDX_CTL_B, {5'h00, CS_EXT_RISE});
        repeat (5) begin
            ext_count_pin_i <= 1'b1;
            idle(5);
            ext_count_pin_i <= 1'b0;
            idle(5);
        end
        rd(IDX_COUNT, 8'h05);
        wr(IDX_CTL_B, {5'h00, CS_EXT_FALL});
        repeat (3) begin
            ext_count_pin_i <= 1'b1;
            idle(5);
            ext_count_pin_i <= 1'b0;
            idle(5);
        end
        rd(IDX_COUNT, 8'h08);
        wr(IDX_CTL_B, {5'h00, CS_STOP});
        $display("test extpin done");
    endtask : t_extpin

    // CTC with compare A as top: no overflow, count read at the end not above the top
    task automatic t_ctc();
        wr(IDX_CTL_A, 8'h42);
        wr(IDX_CMP_A, 8'h03);
        wr(IDX_COUNT, 8'h00);
        wr(IDX_CTL_B, {5'h00, CS_DIV64});
        idle(600);
        wr(IDX_CTL_B, {5'h00, CS_STOP});
        rd(IDX_FLAGS, 8'h02);
        apb(1'b0, IDX_COUNT, 8'h00);
        check({31'h0, rd_q[7:0] <= 8'h03}, 32'h1);
        $display("test ctc done");
    endtask : t_ctc

    // Main sequence: all inputs defined at time zero, reset for 4 cycles
    initial begin
        failures = 0;
        n_checks = 0;
        nrst_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = '0;
        pwdata_i = '0;
        ext_count_pin_i = 1'b0;
        gie_i = 1'b0;
        vec_ack_i = 3'h0;
        idle(4);
        nrst_i <= 1'b1;
        t_reset();
        t_force();
        t_match();
        t_overflow();
        t_extpin();
        t_ctc();
        results();
    end
endmodule : tb_top
